// ---- rtl/tsm_cfg.svh ----
// tsm_cfg.svh: offsets, field positions, reset values and frame counts
// assumes inclusion by bare name from files that need the memory map
`ifndef TSM_CFG_SVH
`define TSM_CFG_SVH

// ----------------------------------------------------------------
// host address map
// ----------------------------------------------------------------
`define TSM_ADDR_W 15
`define TSM_ADDR_MEM_BIT 14
`define TSM_ADDR_STREAM_HI 13
`define TSM_ADDR_STREAM_LO 9
`define TSM_ADDR_SLOT_HI 8
`define TSM_ADDR_SLOT_LO 0
`define TSM_CTRL_OFFSET 14'h0000
`define TSM_ID_OFFSET 14'h3fff

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define TSM_CTRL_MS_HI 2
`define TSM_CTRL_MS_LO 0
`define TSM_CTRL_RESET 16'h0000
`define TSM_MS_LOCAL_ROUTE 3'h0
`define TSM_MS_BP_ROUTE 3'h1
`define TSM_MS_LOCAL_DATA 3'h2
`define TSM_MS_BP_DATA 3'h3

// ----------------------------------------------------------------
// frame geometry
// ----------------------------------------------------------------
`define TSM_STREAMS 16
`define TSM_SLOTS 512
`define TSM_DEPTH 8192
`define TSM_LAST_BIT 3'h7

`endif

// ---- rtl/tsm_pkg.sv ----
// tsm_pkg: types shared by the time-slot switch memory map
// assumes tsm_cfg.svh is available on the include path
package tsm_pkg;

    typedef enum logic [1:0] {
        TSM_ROUTE_SRC_BP = 2'h0,
        TSM_ROUTE_SRC_LOCAL = 2'h1
    } tsm_src_type;

    // one local route table word
    typedef struct packed {
        logic route_source_port;
        logic per_slot_message_flag;
        logic slot_drive_enable;
        logic [3:0] route_source_stream;
        logic [8:0] route_source_slot;
    } tsm_route_type;

    // one host access request
    typedef struct packed {
        logic sel;
        logic wr;
        logic [14:0] addr;
        logic [15:0] wdata;
    } tsm_host_req_type;

endpackage

// ---- rtl/tsm_switch.sv ----
// tsm_switch: host memory map, input byte stores, local route table and
// local serial output path of a 16-stream time-slot switch
// assumes host port and serial timing strobes come from logic on mclk_i
//
// Summary of operation
// [RULE1] address bit 14 high reaches memories, low reaches registers
// [RULE2] memory_select_field of the control register picks which memory is reached
// [RULE3] address bits 13..9 give the stream, streams 0..15 in use
// [RULE4] address bits 8..0 give the channel, channels 0..511 in use
// [RULE5] each received serial channel becomes a byte stored in its port's store
// [RULE6] local input byte store holds 8192 bytes, host read only
// [RULE7] data store reads return zero upper byte, stored byte below
// [RULE8] stored bit 7 is the first bit received in the slot
// [RULE9] backplane input byte store likewise holds 8192 read-only bytes
// [RULE10] local route table holds 8192 sixteen-bit words, one per output slot
// [RULE11] bit 15 picks source store: low backplane, high local; ignored in message
// [RULE12] bit 14 high sends the word's message byte instead of switched data
// [RULE13] bit 13 enables the slot; when low, idle-state pin picks float or buffer
// [RULE14] bits 12..9 give the source stream, ignored in message mode
// [RULE15] bits 8..0 give the source channel while message mode is clear
// [RULE16] message byte goes out most significant bit first in both bus modes
// [RULE17] host sets select to 000 for local, 001 for backplane route table
// [RULE18] data store writes ignored; route table reads return last written word
// [RULE19] a changed route word takes effect at the slot's next transmission
`timescale 1ns/10ps
`include "tsm_cfg.svh"

module tsm_switch
    import tsm_pkg::*;
#(
    parameter logic [15:0] ID_VALUE = 16'h5a01 // arbitrary identification value
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic host_sel_i,
    input wire logic host_wr_i,
    input wire logic [14:0] host_addr_i,
    input wire logic [15:0] host_wdata_i,
    output logic [15:0] host_rdata_o,
    output logic host_ack_o,
    input wire logic frame_start_i,
    input wire logic bit_tick_i,
    input wire logic [15:0] local_serial_inputs_i,
    input wire logic [15:0] bp_serial_inputs_i,
    input wire logic local_idle_state_pin_i,
    output logic [15:0] local_serial_outputs_o,
    output logic [15:0] local_serial_outputs_oe_o,
    output logic [15:0] slot_drive_enable_o
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic [12:0] store_index(input logic [3:0] stream,
                                                input logic [8:0] slot);
        store_index = {stream, slot};
    endfunction

    function automatic tsm_route_type to_route(input logic [15:0] word);
        to_route = tsm_route_type'(word);
    endfunction

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] local_input_byte_store [0:`TSM_DEPTH-1];
    logic [7:0] backplane_input_byte_store [0:`TSM_DEPTH-1];
    logic [15:0] local_route_table [0:`TSM_DEPTH-1];

    // ----------------------------------------------------------------
    // host request decode
    // ----------------------------------------------------------------
    tsm_host_req_type req;
    logic [15:0] ctrl_reg;
    logic [2:0] memory_select_field;
    logic mem_access;
    logic stream_in_use;
    logic [12:0] host_index;
    logic reg_ctrl_hit;
    logic reg_id_hit;
    logic route_wr;
    logic ctrl_wr;
    logic [15:0] mem_rdata;
    logic [15:0] reg_rdata;
    logic [15:0] rdata_next;

    assign req = '{sel: host_sel_i, wr: host_wr_i, addr: host_addr_i, wdata: host_wdata_i};
    assign memory_select_field = ctrl_reg[`TSM_CTRL_MS_HI:`TSM_CTRL_MS_LO];
    assign mem_access = req.addr[`TSM_ADDR_MEM_BIT]; // see [RULE1]
    // streams 16..31 decode to nothing
    assign stream_in_use = ~req.addr[`TSM_ADDR_STREAM_HI]; // see [RULE3]
    assign host_index = store_index(req.addr[`TSM_ADDR_STREAM_HI-1:`TSM_ADDR_STREAM_LO],
                                    req.addr[`TSM_ADDR_SLOT_HI:`TSM_ADDR_SLOT_LO]); // see [RULE4]
    assign reg_ctrl_hit = ~mem_access && (req.addr[13:0] == `TSM_CTRL_OFFSET);
    assign reg_id_hit = ~mem_access && (req.addr[13:0] == `TSM_ID_OFFSET);
    assign ctrl_wr = req.sel && req.wr && reg_ctrl_hit;
    // of the memories, only the local route table accepts host data; data stores are fed by the link
    assign route_wr = req.sel && req.wr && mem_access && stream_in_use
                      && (memory_select_field == `TSM_MS_LOCAL_ROUTE); // see [RULE2] [RULE18]

    always_comb begin
        mem_rdata = 16'h0000;
        if (stream_in_use) begin
            case (memory_select_field) // see [RULE2] [RULE17]
                `TSM_MS_LOCAL_ROUTE: begin
                    mem_rdata = local_route_table[host_index]; // see [RULE18]
                end
                `TSM_MS_LOCAL_DATA: begin
                    mem_rdata = {8'h00, local_input_byte_store[host_index]}; // see [RULE7]
                end
                `TSM_MS_BP_DATA: begin
                    mem_rdata = {8'h00, backplane_input_byte_store[host_index]}; // see [RULE7]
                end
                default: begin
                    // backplane route table lives outside this block
                    mem_rdata = 16'h0000;
                end
            endcase
        end
    end

    assign reg_rdata = reg_ctrl_hit ? ctrl_reg : (reg_id_hit ? ID_VALUE : 16'h0000);
    assign rdata_next = mem_access ? mem_rdata : reg_rdata; // see [RULE1]

    // ----------------------------------------------------------------
    // host registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= `TSM_CTRL_RESET;
            host_rdata_o <= 16'h0000;
            host_ack_o <= 1'b0;
        end else begin
            host_ack_o <= req.sel;
            if (ctrl_wr) begin
                ctrl_reg <= req.wdata;
            end
            if (req.sel && !req.wr) begin
                host_rdata_o <= rdata_next;
            end
        end
    end

    // memory array has no reset; contents are undefined until written
    always_ff @(posedge mclk_i) begin
        if (route_wr) begin
            local_route_table[host_index] <= req.wdata; // see [RULE10]
        end
    end

    // ----------------------------------------------------------------
    // frame timing
    // ----------------------------------------------------------------
    logic [2:0] bit_cnt_reg;
    logic [8:0] slot_cnt_reg;
    logic [2:0] bit_cnt_next;
    logic [8:0] slot_cnt_next;
    logic slot_start;
    logic slot_end;

    assign slot_start = bit_tick_i && (bit_cnt_reg == 3'h0);
    assign slot_end = bit_tick_i && (bit_cnt_reg == `TSM_LAST_BIT);
    assign bit_cnt_next = frame_start_i ? 3'h0 : (bit_tick_i ? bit_cnt_reg + 3'h1 : bit_cnt_reg);
    assign slot_cnt_next = frame_start_i ? 9'h000 :
                           (slot_end ? slot_cnt_reg + 9'h001 : slot_cnt_reg);

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bit_cnt_reg <= 3'h0;
            slot_cnt_reg <= 9'h000;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            slot_cnt_reg <= slot_cnt_next;
        end
    end

    // ----------------------------------------------------------------
    // serial to parallel input
    // ----------------------------------------------------------------
    logic [7:0] local_shift_reg [0:`TSM_STREAMS-1];
    logic [7:0] bp_shift_reg [0:`TSM_STREAMS-1];
    logic frame_go_reg;

    // first bit in lands at bit 7 once eight bits have passed
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            frame_go_reg <= 1'b0;
            for (int i = 0; i < `TSM_STREAMS; i++) begin
                local_shift_reg[i] <= 8'h00;
                bp_shift_reg[i] <= 8'h00;
            end
        end else begin
            if (frame_start_i) begin
                frame_go_reg <= 1'b1;
            end
            if (bit_tick_i) begin
                for (int i = 0; i < `TSM_STREAMS; i++) begin
                    local_shift_reg[i] <= {local_shift_reg[i][6:0],
                                           local_serial_inputs_i[i]}; // see [RULE8]
                    bp_shift_reg[i] <= {bp_shift_reg[i][6:0], bp_serial_inputs_i[i]};
                end
            end
        end
    end

    // the eighth bit is merged directly so the byte is stored on the last tick
    always_ff @(posedge mclk_i) begin
        if (slot_end && frame_go_reg) begin
            for (int i = 0; i < `TSM_STREAMS; i++) begin
                local_input_byte_store[store_index(4'(i), slot_cnt_reg)] <=
                    {local_shift_reg[i][6:0], local_serial_inputs_i[i]}; // see [RULE5] [RULE6]
                backplane_input_byte_store[store_index(4'(i), slot_cnt_reg)] <=
                    {bp_shift_reg[i][6:0], bp_serial_inputs_i[i]}; // see [RULE5] [RULE9]
            end
        end
    end

    // ----------------------------------------------------------------
    // idle-state pin synchroniser
    // ----------------------------------------------------------------
    logic idle_meta_reg;
    logic idle_sync_reg;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            idle_meta_reg <= 1'b0;
            idle_sync_reg <= 1'b0;
        end else begin
            idle_meta_reg <= local_idle_state_pin_i;
            idle_sync_reg <= idle_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // route lookup and parallel to serial output
    // ----------------------------------------------------------------
    tsm_route_type route_word [0:`TSM_STREAMS-1];
    logic [7:0] tx_byte [0:`TSM_STREAMS-1];
    logic [7:0] tx_shift_reg [0:`TSM_STREAMS-1];
    logic [15:0] tx_bit_reg;
    logic [15:0] tx_en_reg;

    // route word sampled at slot start, so a host update lands at the slot's next start
    always_comb begin
        for (int i = 0; i < `TSM_STREAMS; i++) begin
            route_word[i] = to_route(local_route_table[store_index(4'(i), slot_cnt_reg)]);
            if (route_word[i].per_slot_message_flag) begin
                tx_byte[i] = route_word[i].route_source_slot[7:0]; // see [RULE12] [RULE16]
            end else if (route_word[i].route_source_port) begin
                tx_byte[i] = local_input_byte_store[store_index(
                    route_word[i].route_source_stream,
                    route_word[i].route_source_slot)]; // see [RULE11] [RULE14] [RULE15]
            end else begin
                tx_byte[i] = backplane_input_byte_store[store_index(
                    route_word[i].route_source_stream,
                    route_word[i].route_source_slot)]; // see [RULE11] [RULE14] [RULE15]
            end
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_bit_reg <= 16'hffff;
            tx_en_reg <= 16'h0000;
            for (int i = 0; i < `TSM_STREAMS; i++) begin
                tx_shift_reg[i] <= 8'h00;
            end
        end else if (slot_start && frame_go_reg) begin
            for (int i = 0; i < `TSM_STREAMS; i++) begin
                tx_bit_reg[i] <= tx_byte[i][7]; // see [RULE16]
                tx_shift_reg[i] <= {tx_byte[i][6:0], 1'b0};
                tx_en_reg[i] <= route_word[i].slot_drive_enable; // see [RULE13] [RULE19]
            end
        end else if (bit_tick_i && frame_go_reg) begin
            for (int i = 0; i < `TSM_STREAMS; i++) begin
                tx_bit_reg[i] <= tx_shift_reg[i][7];
                tx_shift_reg[i] <= {tx_shift_reg[i][6:0], 1'b0};
            end
        end
    end

    // ----------------------------------------------------------------
    // output pins
    // ----------------------------------------------------------------
    // disabled slot: pin low floats the output, pin high drives high and an
    // external buffer is steered by slot_drive_enable_o
    logic [15:0] drive_idle_high;

    assign drive_idle_high = {16{idle_sync_reg}};
    assign local_serial_outputs_o = tx_bit_reg | ~tx_en_reg; // see [RULE13]
    assign local_serial_outputs_oe_o = tx_en_reg | drive_idle_high; // see [RULE13]
    assign slot_drive_enable_o = tx_en_reg;

endmodule

// ---- dv/tsm_switch_properties.sv ----
// tsm_switch_properties: port checks of host access and serial output
// assumes bound to tsm_switch, one clock, reset async high
`timescale 1ns/10ps
module tsm_switch_properties #(
    parameter logic [15:0] ID_VALUE = 16'h5a01
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic host_sel_i,
    input wire logic host_wr_i,
    input wire logic [14:0] host_addr_i,
    input wire logic [15:0] host_wdata_i,
    input wire logic [15:0] host_rdata_o,
    input wire logic host_ack_o,
    input wire logic frame_start_i,
    input wire logic bit_tick_i,
    input wire logic [15:0] local_serial_inputs_i,
    input wire logic [15:0] bp_serial_inputs_i,
    input wire logic local_idle_state_pin_i,
    input wire logic [15:0] local_serial_outputs_o,
    input wire logic [15:0] local_serial_outputs_oe_o,
    input wire logic [15:0] slot_drive_enable_o
);
    logic [2:0] ms_reg;
    logic mem_rd;
    assign mem_rd = host_sel_i && !host_wr_i && host_addr_i[14];
    // shadow of the select field, so reads can be classified
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ms_reg <= 3'h0;
        end else if (host_sel_i && host_wr_i && host_addr_i == 15'h0000) begin
            ms_reg <= host_wdata_i[2:0];
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // ------
    // host side
    // ------
    chk_ack_follows: assert property (host_sel_i |=> host_ack_o)
        else $error("ack missing");
    chk_ack_only: assert property (!host_sel_i |=> !host_ack_o)
        else $error("ack without access");
    chk_rdata_holds: assert property (!(host_sel_i && !host_wr_i) |=> $stable(host_rdata_o))
        else $error("read data moved");
    chk_id_read: assert property (host_sel_i && !host_wr_i && host_addr_i == 15'h3fff
        |=> host_rdata_o == ID_VALUE) else $error("id value wrong");
    chk_store_upper: assert property (mem_rd && ms_reg[2:1] == 2'h1
        |=> host_rdata_o[15:8] == 8'h00) else $error("store upper byte set");
    chk_bp_route: assert property (mem_rd && ms_reg == 3'h1 |=> host_rdata_o == 16'h0000)
        else $error("external table read not zero");
    // ------
    // serial side
    // ------
    chk_enabled_drives: assert property ((slot_drive_enable_o & ~local_serial_outputs_oe_o) == 16'h0000)
        else $error("enabled slot not driven");
    chk_disabled_high: assert property ((local_serial_outputs_o | slot_drive_enable_o) == 16'hffff)
        else $error("disabled slot not high");
    chk_idle_float: assert property (!local_idle_state_pin_i [*4]
        |-> local_serial_outputs_oe_o == slot_drive_enable_o) else $error("idle slot driven");
    chk_out_stands: assert property (!bit_tick_i
        |=> $stable({local_serial_outputs_o, slot_drive_enable_o})) else $error("output moved");
endmodule

// ---- dv/tsm_host_model.sv ----
// tsm_host_model: host processor issuing single-cycle word accesses
// assumes ack registered on the taking edge, read data with it
`timescale 1ns/10ps
module tsm_host_model
    import tsm_pkg::*;
(
    input wire logic mclk_i,
    input wire logic [15:0] host_rdata_i,
    input wire logic host_ack_i,
    output tsm_host_req_type req_o
);
    int ack_miss = 0;
    initial req_o = '0;
    function automatic logic [14:0] mem_addr(input logic [4:0] strm, input logic [8:0] slot);
        return {1'b1, strm, slot};
    endfunction
    // held for exactly one edge: a longer select would repeat the access
    task automatic access(input logic wr, input logic [14:0] a, input logic [15:0] wd,
                          output logic [15:0] rd);
        @(posedge mclk_i);
        #2;
        req_o = '{1'b1, wr, a, wd};
        @(posedge mclk_i);
        #2;
        // released lines do not keep the old value
        req_o = '{1'b0, ~wr, ~a, ~wd};
        if (host_ack_i !== 1'b1) ack_miss++;
        rd = host_rdata_i;
    endtask
    task automatic select_mem(input logic [2:0] ms);
        logic [15:0] d;
        access(1'b1, 15'h0000, {13'h0000, ms}, d);
    endtask
endmodule

// ---- dv/test_tsm_switch.sv ----
// test_tsm_switch: directed host and serial tests of tsm_switch
// assumes tsm_pkg compiled first and tsm_cfg.svh on the include path
`timescale 1ns/10ps
module test_tsm_switch
    import tsm_pkg::*;
;
    localparam logic [15:0] ID_VALUE = 16'h3c96; // arbitrary identification value
    logic mclk_i = 0, sys_rst_i = 1, fstart = 0, btick = 0, idle = 0;
    logic [15:0] lin = '0, bin = '0, rdata, sout, soe, sen, rd;
    logic ack;
    tsm_host_req_type req;
    int n_fail = 0, tests_run = 0;
    logic [7:0] cap [4];
    initial forever #12.5 mclk_i = ~mclk_i;
    tsm_host_model u_host (.mclk_i(mclk_i), .host_rdata_i(rdata), .host_ack_i(ack), .req_o(req));
    tsm_switch #(.ID_VALUE(ID_VALUE)) DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .host_sel_i(req.sel), .host_wr_i(req.wr), .host_addr_i(req.addr),
        .host_wdata_i(req.wdata), .host_rdata_o(rdata), .host_ack_o(ack),
        .frame_start_i(fstart), .bit_tick_i(btick), .local_serial_inputs_i(lin),
        .bp_serial_inputs_i(bin), .local_idle_state_pin_i(idle),
        .local_serial_outputs_o(sout), .local_serial_outputs_oe_o(soe),
        .slot_drive_enable_o(sen));
    // ------
    // helpers
    // ------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [14:0] a, input logic [15:0] d);
        u_host.access(1'b1, a, d, rd);
    endtask
    task automatic rdc(input string what, input logic [14:0] a, input logic [15:0] exp);
        u_host.access(1'b0, a, 16'h0000, rd);
        check(what, rd, exp);
    endtask
    // first bit on the wire is byte bit 7; local stream 2, backplane stream 3
    task automatic run_slot(input logic [7:0] lb, input logic [7:0] bb);
        for (int b = 7; b >= 0; b--) begin
            @(posedge mclk_i);
            #2;
            lin = {13'h0000, lb[b], 2'h0};
            bin = {12'h000, bb[b], 3'h0};
            btick = 1;
            @(posedge mclk_i);
            #2;
            btick = 0;
            for (int s = 0; s < 4; s++) cap[s] = {cap[s][6:0], sout[s]};
        end
    endtask
    task automatic run_frame();
        @(posedge mclk_i);
        #2;
        fstart = 1;
        @(posedge mclk_i);
        #2;
        fstart = 0;
        run_slot(8'hc3, 8'h5a);
        run_slot(8'h00, 8'h00);
    endtask
    // ------
    // tests
    // ------
    initial begin
        repeat (5) @(posedge mclk_i);
        #2;
        sys_rst_i = 0;
        check("rdata_rst", rdata, 16'h0000);
        check("out_rst", sout, 16'hffff);
        check("en_rst", sen, 16'h0000);
        rdc("ctrl_rst", 15'h0000, 16'h0000);
        rdc("id", 15'h3fff, ID_VALUE);
        $display("test reset done");
        u_host.select_mem(3'h0);
        // route table powers up unknown; clear every slot the frames will use
        for (int s = 0; s < 16; s++) begin
            wr(u_host.mem_addr(5'(s), 9'd0), 16'h0000);
            wr(u_host.mem_addr(5'(s), 9'd1), 16'h0000);
        end
        wr(15'h4000, 16'h1111);
        wr(u_host.mem_addr(5'd0, 9'd1), 16'h60a5);
        wr(u_host.mem_addr(5'd1, 9'd1), 16'ha400);
        wr(u_host.mem_addr(5'd2, 9'd1), 16'h2600);
        wr(u_host.mem_addr(5'd15, 9'd511), 16'hbeef);
        wr(u_host.mem_addr(5'd16, 9'd1), 16'h1234);
        rdc("mem_side", 15'h4000, 16'h1111);
        rdc("reg_side", 15'h0000, 16'h0000);
        rdc("route_0_1", u_host.mem_addr(5'd0, 9'd1), 16'h60a5);
        rdc("route_15_511", u_host.mem_addr(5'd15, 9'd511), 16'hbeef);
        rdc("stream_16", u_host.mem_addr(5'd16, 9'd1), 16'h0000);
        u_host.select_mem(3'h1);
        wr(u_host.mem_addr(5'd0, 9'd1), 16'h5555);
        rdc("bp_route", u_host.mem_addr(5'd0, 9'd1), 16'h0000);
        $display("test host map done");
        idle = 1;
        run_frame();
        check("msg_out", {8'h00, cap[0]}, 16'h00a5);
        check("local_src", {8'h00, cap[1]}, 16'h00c3);
        check("bp_src", {8'h00, cap[2]}, 16'h005a);
        check("off_slot", {8'h00, cap[3]}, 16'h00ff);
        check("slot_en", sen, 16'h0007);
        check("oe_idle_hi", soe, 16'hffff);
        idle = 0;
        repeat (4) @(posedge mclk_i);
        #2;
        check("oe_idle_lo", soe, 16'h0007);
        u_host.select_mem(3'h2);
        rdc("local_store", u_host.mem_addr(5'd2, 9'd0), 16'h00c3);
        wr(u_host.mem_addr(5'd2, 9'd0), 16'hffff);
        rdc("store_ro", u_host.mem_addr(5'd2, 9'd0), 16'h00c3);
        u_host.select_mem(3'h3);
        rdc("bp_store", u_host.mem_addr(5'd3, 9'd0), 16'h005a);
        $display("test switching done");
        u_host.select_mem(3'h0);
        wr(u_host.mem_addr(5'd0, 9'd1), 16'h603c);
        run_frame();
        check("new_msg", {8'h00, cap[0]}, 16'h003c);
        check("acks", 16'(u_host.ack_miss), 16'h0000);
        $display("test route update done");
        end_sim();
    end
    // whole run is under 1000 cycles; this span leaves a wide margin
    initial begin
        #100000;
        n_fail++;
        end_sim();
    end
endmodule

bind tsm_switch tsm_switch_properties #(.ID_VALUE(ID_VALUE)) u_props (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .host_sel_i(host_sel_i), .host_wr_i(host_wr_i),
    .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
    .host_ack_o(host_ack_o), .frame_start_i(frame_start_i), .bit_tick_i(bit_tick_i),
    .local_serial_inputs_i(local_serial_inputs_i), .bp_serial_inputs_i(bp_serial_inputs_i),
    .local_idle_state_pin_i(local_idle_state_pin_i),
    .local_serial_outputs_o(local_serial_outputs_o),
    .local_serial_outputs_oe_o(local_serial_outputs_oe_o),
    .slot_drive_enable_o(slot_drive_enable_o));
